// *** design/vrocm_stage.sv ***
// Restrained overcurrent stage: pick-up, blocking, timing, status, counters.
// Assumes measurements update with cycle_strobe and that a millisecond
// time base is provided by the system clock of the relay.
`timescale 1ns/10ps
// Summary of operation
// - Sample blocking at each processing cycle start
// - Unblocked pick-up asserts start, begins operate timing
// - Blocked pick-up asserts blocked, no start/trip
// - Blocking during start clears start, runs release
// - Definite or inverse delay from current ratio
// - Expected operate time in 5 ms steps
// - Signed remaining trip time while counting
// - Voltage status invalid, unavailable or ok
// - Publish applied pick-up level, 0.01 xIn
// - Publish positive sequence voltage, 0.01 %Un
// - Publish highest current to pick-up ratio
// - Publish operating mode and condition
// - Six on/off events for start, trip, blocked
// - Per-event on/off buffer selection
// - Time stamp every event
// - Resettable start, trip, blocked counters
// - Keep latest twelve records, overwrite oldest
// - Store fault record on each on-event
// - Outputs usable for direct and logic control
// - Release below 97 percent of pick-up
// - Equal knees stepped, else restrained curve
module vrocm_stage
  import vrocm_pkg::*;
#(
  parameter int STEP_CYC = TIME_STEP_CYC,
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Program cycle and time base
  input wire logic cycle_strobe,
  input wire logic [47:0] time_ms,
  // Measurement and blocking
  input wire vrocm_meas_t meas,
  input wire logic block_in,
  // Configuration
  input wire vrocm_setting_t setting,
  input wire vrocm_mode_t mode,
  input wire vrocm_wiring_t wiring,
  input wire logic residual_voltage_channel,
  input wire logic [5:0] event_enable,
  input wire logic [2:0] counter_clear,
  input wire logic [3:0] record_index,
  // Protection outputs
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  // Live status
  output vrocm_mode_t mode_status,
  output vrocm_cond_t condition,
  output vrocm_vstat_t voltage_status,
  output logic [15:0] pickup_now,
  output logic [15:0] voltage_now,
  output logic [15:0] ratio_now,
  output logic [18:0] expected_time,
  output logic [19:0] remaining_time,
  output logic [2:0] faulted_phases,
  // Counters
  output logic [CNT_W-1:0] start_count,
  output logic [CNT_W-1:0] trip_count,
  output logic [CNT_W-1:0] block_count,
  // Event buffer and records
  output logic event_out_valid,
  output vrocm_event_msg_t event_out,
  output vrocm_record_t record_out,
  output logic [3:0] record_count
);

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] pickup_comb;
  logic [15:0] i_max;
  logic [15:0] i_phase [3];
  logic [2:0] over_phase;
  logic [2:0] under_release;
  logic picked_reg;
  logic block_reg;
  logic active;
  logic [18:0] op_delay;
  logic [18:0] elapsed_reg;
  logic [18:0] release_reg;
  logic [$clog2(STEP_CYC+1)-1:0] step_div_reg;
  logic step_tick;
  logic [15:0] hist_reg [PRE_FAULT_STEPS+1];
  logic ev_valid;
  vrocm_event_t ev_code;
  vrocm_record_t rec;
  logic start_next;
  logic trip_next;
  logic blocked_next;

  assign i_phase[0] = meas.il1;
  assign i_phase[1] = meas.il2;
  assign i_phase[2] = meas.il3;
  assign active = (mode != VROCM_MODE_OFF) && (mode != VROCM_MODE_BLOCKED)
               && (mode != VROCM_MODE_TEST_BLOCKED);

  vrocm_pickup_curve u_curve (
    .lower_current_knee(setting.lower_current_knee),
    .upper_current_knee(setting.upper_current_knee),
    .lower_voltage_knee(setting.lower_voltage_knee),
    .upper_voltage_knee(setting.upper_voltage_knee),
    .positive_sequence_voltage(meas.positive_sequence_voltage),
    .pickup_level(pickup_comb)
  );

  // Per-phase pick-up and 97 % release comparisons.
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    assign over_phase[p] = i_phase[p] > pickup_comb;
    assign under_release[p] = (32'(i_phase[p]) * 100) < (32'(pickup_comb) * RELEASE_PCT);
  end

  always_comb
  begin
    i_max = meas.il1;
    if (meas.il2 > i_max)
    begin
      i_max = meas.il2;
    end
    if (meas.il3 > i_max)
    begin
      i_max = meas.il3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 5 ms time step divider; all delays count in these steps.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      step_div_reg <= '0;
    end
    else if (step_tick)
    begin
      step_div_reg <= '0;
    end
    else
    begin
      step_div_reg <= step_div_reg + 1'b1;
    end
  end
  assign step_tick = (step_div_reg == ($bits(step_div_reg))'(STEP_CYC - 1));

  // Current history for pre-trigger and pre-fault values.
  always_ff @(posedge ref_clk)
  begin
    if (step_tick)
    begin
      hist_reg[0] <= i_max;
      for (int k = 1; k <= PRE_FAULT_STEPS; k++)
      begin
        hist_reg[k] <= hist_reg[k-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Inverse time: delay = multiplier * 100 / (ratio - 100), ratio in 0.01 steps; a simple curve
  // stands in for the general family, which lives outside this stage.
  always_comb
  begin
    op_delay = setting.definite_time_delay;
    if (setting.inverse_sel && (ratio_now > RATIO_UNITY))
    begin
      op_delay = 19'((32'(setting.inverse_time_mult) * 100) / 32'(ratio_now - RATIO_UNITY));
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      block_reg <= 1'b0;
      picked_reg <= 1'b0;
      pickup_now <= '0;
      voltage_now <= '0;
      ratio_now <= '0;
      faulted_phases <= '0;
    end
    else if (cycle_strobe)
    begin
      block_reg <= block_in;
      pickup_now <= pickup_comb;
      voltage_now <= meas.positive_sequence_voltage;
      ratio_now <= (pickup_comb == 16'h0) ? 16'hFFFF
                 : 16'((32'(i_max) * 100) / 32'(pickup_comb));
      faulted_phases <= over_phase;
      if (|over_phase)
      begin
        picked_reg <= 1'b1;
      end
      else if (&under_release)
      begin
        picked_reg <= 1'b0;
      end
    end
  end

  // Start, trip and blocked decisions using the block sampled at the previous processing cycle.
  always_comb
  begin
    start_next = start_out;
    trip_next = trip_out;
    blocked_next = blocked_out;
    if (cycle_strobe)
    begin
      blocked_next = active && picked_reg && block_reg;
      start_next = active && picked_reg && !block_reg;
      trip_next = start_next && (trip_out || elapsed_reg >= op_delay);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end
    else
    begin
      start_out <= start_next;
      trip_out <= trip_next;
      blocked_out <= blocked_next;
    end
  end

  // Operate timer; on start loss the release timer holds the count a while.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      elapsed_reg <= '0;
      release_reg <= '0;
    end
    else if (start_out)
    begin
      release_reg <= setting.release_delay;
      if (step_tick && elapsed_reg != 19'(TIME_MAX_STEPS))
      begin
        elapsed_reg <= elapsed_reg + 19'h1;
      end
    end
    else if (step_tick)
    begin
      if (release_reg != 19'h0)
      begin
        release_reg <= release_reg - 19'h1;
      end
      else
      begin
        elapsed_reg <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      expected_time <= '0;
      remaining_time <= '0;
    end
    else
    begin
      expected_time <= op_delay;
      remaining_time <= start_out ? 20'(signed'({1'b0, op_delay}) - signed'({1'b0, elapsed_reg}))
                      : 20'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      voltage_status <= VROCM_VSTAT_INVALID;
      mode_status <= VROCM_MODE_ON;
      condition <= VROCM_COND_NORMAL;
    end
    else
    begin
      if (!meas.voltage_valid)
      begin
        voltage_status <= VROCM_VSTAT_INVALID;
      end
      else if ((wiring == VROCM_WIRE_3LL_U4 || wiring == VROCM_WIRE_2LL_U3_U4)
               && !residual_voltage_channel)
      begin
        voltage_status <= VROCM_VSTAT_POSSEQ_NA;
      end
      else
      begin
        voltage_status <= VROCM_VSTAT_OK;
      end
      mode_status <= mode;
      if (trip_next)
      begin
        condition <= VROCM_COND_TRIP;
      end
      else if (start_next)
      begin
        condition <= VROCM_COND_START;
      end
      else if (blocked_next)
      begin
        condition <= VROCM_COND_BLOCKED;
      end
      else
      begin
        condition <= VROCM_COND_NORMAL;
      end
    end
  end

  // Counters: an occurrence in the clear cycle still counts.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_count <= '0;
      trip_count <= '0;
      block_count <= '0;
    end
    else
    begin
      if (start_next && !start_out)
        start_count <= counter_clear[0] ? CNT_W'(1) : start_count + 1'b1;
      else if (counter_clear[0])
        start_count <= '0;
      if (trip_next && !trip_out)
        trip_count <= counter_clear[1] ? CNT_W'(1) : trip_count + 1'b1;
      else if (counter_clear[1])
        trip_count <= '0;
      if (blocked_next && !blocked_out)
        block_count <= counter_clear[2] ? CNT_W'(1) : block_count + 1'b1;
      else if (counter_clear[2])
        block_count <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One event per clock; on edges win, as they also store the records.
  // A simultaneous lower-priority edge is lost, a known limitation.
  always_comb
  begin
    ev_valid = 1'b1;
    ev_code = VROCM_EV_START_ON;
    if (trip_next && !trip_out)
      ev_code = VROCM_EV_TRIP_ON;
    else if (start_next && !start_out)
      ev_code = VROCM_EV_START_ON;
    else if (blocked_next && !blocked_out)
      ev_code = VROCM_EV_BLOCK_ON;
    else if (!trip_next && trip_out)
      ev_code = VROCM_EV_TRIP_OFF;
    else if (!start_next && start_out)
      ev_code = VROCM_EV_START_OFF;
    else if (!blocked_next && blocked_out)
      ev_code = VROCM_EV_BLOCK_OFF;
    else
      ev_valid = 1'b0;
  end

  always_comb
  begin
    rec.stamp_ms = time_ms;
    rec.event_code = ev_code;
    rec.faulted_phases = over_phase;
    rec.pre_trigger_current = hist_reg[PRE_TRIG_STEPS];
    rec.fault_current = i_max;
    rec.positive_sequence_voltage = meas.positive_sequence_voltage;
    rec.pickup_level = pickup_comb;
    rec.pre_fault_current = hist_reg[PRE_FAULT_STEPS];
    rec.trip_remaining = remaining_time;
    rec.setting_group = setting.setting_group;
  end

  vrocm_event_log #(
    .DEPTH(HIST_DEPTH)
  ) u_log (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .event_valid(ev_valid),
    .event_code(ev_code),
    .event_enable(event_enable),
    .record_in(rec),
    .event_out_valid(event_out_valid),
    .event_out(event_out),
    .record_index(record_index),
    .record_out(record_out),
    .record_count(record_count)
  );

endmodule

// *** design/vrocm_pkg.sv ***
// Package for the restrained overcurrent stage: field widths, encodings,
// reset values and timing counts shared by the stage and its helpers.
// Assumes a 40 MHz ref_clk and one processing cycle per cycle_strobe pulse.
package vrocm_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int RELEASE_PCT = 97;
  localparam int BLOCK_LEAD_MS = 5;
  localparam int BLOCK_LEAD_CYC = (BLOCK_LEAD_MS * (CLK_HZ / 1000));
  localparam int TIME_STEP_US = 5000;
  localparam int TIME_STEP_CYC = (TIME_STEP_US * (CLK_HZ / 1000000));
  localparam int TIME_MAX_STEPS = 360000;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int HIST_DEPTH = 12;
  localparam int PRE_TRIG_STEPS = PRE_TRIG_MS * 1000 / TIME_STEP_US;
  localparam int PRE_FAULT_STEPS = PRE_FAULT_MS * 1000 / TIME_STEP_US;
  localparam logic [15:0] RATIO_UNITY = 16'h0064;
  localparam logic [15:0] KNEE_LO_I_RST = 16'h0014;
  localparam logic [15:0] KNEE_HI_I_RST = 16'h0078;
  localparam logic [15:0] KNEE_LO_U_RST = 16'h07D0;
  localparam logic [15:0] KNEE_HI_U_RST = 16'h2710;

  typedef enum logic [2:0] {
    VROCM_MODE_ON,
    VROCM_MODE_BLOCKED,
    VROCM_MODE_TEST,
    VROCM_MODE_TEST_BLOCKED,
    VROCM_MODE_OFF
  } vrocm_mode_t;

  typedef enum logic [1:0] {
    VROCM_COND_NORMAL,
    VROCM_COND_START,
    VROCM_COND_TRIP,
    VROCM_COND_BLOCKED
  } vrocm_cond_t;

  typedef enum logic [1:0] {
    VROCM_VSTAT_INVALID,
    VROCM_VSTAT_POSSEQ_NA,
    VROCM_VSTAT_OK
  } vrocm_vstat_t;

  typedef enum logic [2:0] {
    VROCM_EV_START_ON,
    VROCM_EV_START_OFF,
    VROCM_EV_TRIP_ON,
    VROCM_EV_TRIP_OFF,
    VROCM_EV_BLOCK_ON,
    VROCM_EV_BLOCK_OFF
  } vrocm_event_t;

  typedef enum logic [2:0] {
    VROCM_WIRE_3LN,
    VROCM_WIRE_3LL_U4,
    VROCM_WIRE_2LL_U3_U4,
    VROCM_WIRE_OTHER
  } vrocm_wiring_t;

  typedef struct packed {
    logic [15:0] lower_current_knee;
    logic [15:0] upper_current_knee;
    logic [15:0] lower_voltage_knee;
    logic [15:0] upper_voltage_knee;
    logic inverse_sel;
    logic [18:0] definite_time_delay;
    logic [15:0] inverse_time_mult;
    logic [18:0] release_delay;
    logic [2:0] setting_group;
  } vrocm_setting_t;

  typedef struct packed {
    logic [15:0] il1;
    logic [15:0] il2;
    logic [15:0] il3;
    logic [15:0] positive_sequence_voltage;
    logic voltage_valid;
  } vrocm_meas_t;

  typedef struct packed {
    logic [47:0] stamp_ms;
    vrocm_event_t event_code;
    logic [2:0] faulted_phases;
    logic [15:0] pre_trigger_current;
    logic [15:0] fault_current;
    logic [15:0] positive_sequence_voltage;
    logic [15:0] pickup_level;
    logic [15:0] pre_fault_current;
    logic [19:0] trip_remaining;
    logic [2:0] setting_group;
  } vrocm_record_t;

  typedef struct packed {
    logic [47:0] stamp_ms;
    vrocm_event_t event_code;
  } vrocm_event_msg_t;

endpackage

// *** design/vrocm_pickup_curve.sv ***
// Pick-up level from the positive sequence voltage and the four knees.
// Combinational; assumes settings are stable during a processing cycle.
`timescale 1ns/10ps
module vrocm_pickup_curve
  import vrocm_pkg::*;
(
  // Settings and measurement
  input wire logic [15:0] lower_current_knee,
  input wire logic [15:0] upper_current_knee,
  input wire logic [15:0] lower_voltage_knee,
  input wire logic [15:0] upper_voltage_knee,
  input wire logic [15:0] positive_sequence_voltage,
  // Result in 0.01 xIn steps
  output logic [15:0] pickup_level
);

  logic [31:0] span_i;
  logic [31:0] num;
  logic [15:0] span_u;

  always_comb
  begin
    span_i = 32'h0;
    num = 32'h0;
    span_u = upper_voltage_knee - lower_voltage_knee;
    if (positive_sequence_voltage <= lower_voltage_knee)
    begin
      // Equal knees land here below the knee: stepped, voltage-controlled.
      pickup_level = lower_current_knee;
    end
    else if (positive_sequence_voltage >= upper_voltage_knee)
    begin
      pickup_level = upper_current_knee;
    end
    else
    begin
      // A divider here is costly but runs only once per slow program cycle.
      span_i = {16'h0, upper_current_knee} - {16'h0, lower_current_knee};
      num = span_i * {16'h0, positive_sequence_voltage - lower_voltage_knee};
      pickup_level = lower_current_knee + 16'(num / {16'h0, span_u});
    end
  end

endmodule

// *** design/vrocm_event_log.sv ***
// Event filter and twelve-deep fault record ring.
// Assumes the stage presents at most one event per clock.
`timescale 1ns/10ps
module vrocm_event_log
  import vrocm_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Event in
  input wire logic event_valid,
  input wire vrocm_event_t event_code,
  input wire logic [5:0] event_enable,
  input wire vrocm_record_t record_in,
  // Event buffer out
  output logic event_out_valid,
  output vrocm_event_msg_t event_out,
  // Record readback
  input wire logic [3:0] record_index,
  output vrocm_record_t record_out,
  output logic [3:0] record_count
);

  vrocm_record_t ring_reg [DEPTH];
  logic [3:0] wr_ptr_reg;
  logic is_on_event;

  assign is_on_event = (event_code == VROCM_EV_START_ON) || (event_code == VROCM_EV_TRIP_ON)
                    || (event_code == VROCM_EV_BLOCK_ON);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      event_out_valid <= 1'b0;
      event_out <= '0;
    end
    else
    begin
      event_out_valid <= event_valid && event_enable[event_code];
      event_out <= {record_in.stamp_ms, event_code};
    end
  end

  // Oldest entry is overwritten once the ring is full.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= 4'h0;
      record_count <= 4'h0;
    end
    else if (event_valid && is_on_event)
    begin
      wr_ptr_reg <= (wr_ptr_reg == 4'(DEPTH - 1)) ? 4'h0 : wr_ptr_reg + 4'h1;
      if (record_count != 4'(DEPTH))
      begin
        record_count <= record_count + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (event_valid && is_on_event)
    begin
      ring_reg[wr_ptr_reg] <= record_in;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      record_out <= '0;
    end
    else if (record_index < 4'(DEPTH))
    begin
      record_out <= ring_reg[record_index];
    end
  end

endmodule

// *** test/vrocm_partner.sv ***
// Partner model: phase measurement front end and blocking matrix.
// Assumes the stage samples on the rising edge; this model drives on the falling one.
`timescale 1ns/10ps
module vrocm_partner
  import vrocm_pkg::*;
#(
  parameter int PERIOD = 8
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Commands from the bench
  input wire vrocm_meas_t set_meas,
  input wire logic set_block,
  // Towards the stage
  output logic cycle_strobe,
  output vrocm_meas_t meas,
  output logic block_in
);
  logic [7:0] div_reg;

  always @(negedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_reg <= 8'h00;
      cycle_strobe <= 1'b0;
      meas <= '0;
      block_in <= 1'b0;
    end
    else
    begin
      div_reg <= (div_reg == 8'(PERIOD - 1)) ? 8'h00 : div_reg + 8'h01;
      cycle_strobe <= (div_reg == 8'h00);
      // Blocking reaches the stage one clock after the command, far ahead of any delay.
      block_in <= set_block;
      meas <= set_meas;
      // Without a valid voltage the word wanders, so nothing may rely on it.
      if (!set_meas.voltage_valid)
        meas.positive_sequence_voltage <= ~meas.positive_sequence_voltage;
    end
  end
endmodule

// *** test/vrocm_stage_assertions.sv ***
// Checker for the restrained overcurrent stage, bound to its ports.
// Assumes one clock domain and processing cycles a few clocks apart.
`timescale 1ns/10ps
module vrocm_stage_assertions
  import vrocm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Inputs watched
  input wire logic cycle_strobe,
  input wire logic block_in,
  input wire vrocm_meas_t meas,
  input wire vrocm_mode_t mode,
  input wire vrocm_wiring_t wiring,
  input wire logic residual_voltage_channel,
  input wire logic [5:0] event_enable,
  // Outputs watched
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire vrocm_cond_t condition,
  input wire vrocm_vstat_t voltage_status,
  input wire logic [19:0] remaining_time,
  input wire logic event_out_valid,
  input wire vrocm_event_msg_t event_out,
  input wire logic [3:0] record_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_start_on_cycle: assert property ($rose(start_out) |-> $past(cycle_strobe))
    else $error("start rose outside a processing cycle");
  a_blocked_no_start: assert property ($rose(blocked_out) |-> $past(cycle_strobe) && !start_out)
    else $error("blocked rose with start or outside a cycle");
  a_block_clears_start: assert property (start_out && cycle_strobe && block_in |-> ##[1:20] !start_out)
    else $error("start survived blocking");
  a_trip_after_start: assert property ($rose(trip_out) |-> $past(start_out))
    else $error("trip without a preceding start");
  a_trip_condition: assert property (trip_out && $stable(trip_out) |-> condition == VROCM_COND_TRIP)
    else $error("condition does not show trip");
  a_off_forces_low: assert property ((mode == VROCM_MODE_OFF) [*3] ##0 cycle_strobe |=> !(start_out || trip_out || blocked_out))
    else $error("outputs active while off");
  a_start_event: assert property ($rose(start_out) && !trip_out && event_enable[0] |-> event_out_valid && event_out.event_code == VROCM_EV_START_ON)
    else $error("start event missing");
  a_event_filter: assert property (event_out_valid |-> event_enable[event_out.event_code])
    else $error("disabled event reached the buffer");
  a_posseq_flag: assert property ((meas.voltage_valid && !residual_voltage_channel && (wiring == VROCM_WIRE_3LL_U4 || wiring == VROCM_WIRE_2LL_U3_U4)) [*3] |-> voltage_status == VROCM_VSTAT_POSSEQ_NA)
    else $error("voltage status not unavailable");
  a_remaining_idle: assert property ((!start_out && !trip_out) [*2] |-> remaining_time == 20'h00000)
    else $error("remaining time nonzero when idle");
  a_record_depth: assert property (record_count <= 4'hC)
    else $error("record count above depth");
endmodule

bind vrocm_stage vrocm_stage_assertions u_chk (.ref_clk, .reset_n, .cycle_strobe, .block_in, .meas,
  .mode, .wiring, .residual_voltage_channel, .event_enable, .start_out, .trip_out, .blocked_out,
  .condition, .voltage_status, .remaining_time, .event_out_valid, .event_out, .record_count);

// *** test/test_vrocm_stage.sv ***
// Testbench for the restrained overcurrent stage with its measurement partner.
// Assumes a time step of 10 clocks and a strobe every 8 clocks.
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module test_vrocm_stage
  import vrocm_pkg::*;
;
  logic ref_clk, reset_n, cycle_strobe, block_in, set_block, residual_voltage_channel;
  logic [47:0] time_ms;
  vrocm_meas_t meas, set_meas;
  vrocm_setting_t setting;
  vrocm_mode_t mode, mode_status;
  vrocm_wiring_t wiring;
  logic [5:0] event_enable;
  logic [2:0] counter_clear, faulted_phases;
  logic [3:0] record_index, record_count;
  logic start_out, trip_out, blocked_out, event_out_valid;
  vrocm_cond_t condition;
  vrocm_vstat_t voltage_status;
  logic [15:0] pickup_now, voltage_now, ratio_now, start_count, trip_count, block_count;
  logic [18:0] expected_time;
  logic [19:0] remaining_time;
  vrocm_event_msg_t event_out, last_ev;
  vrocm_record_t record_out;
  int error_cnt = 0;
  int n_checks = 0;
  logic [15:0] cv [5][4] = '{'{16'h07D0, 16'h2710, 16'h03E8, 16'h0014},
    '{16'h07D0, 16'h2710, 16'h1770, 16'h0046}, '{16'h07D0, 16'h2710, 16'h2EE0, 16'h0078},
    '{16'h1770, 16'h1770, 16'h1388, 16'h0014}, '{16'h1770, 16'h1770, 16'h1B58, 16'h0078}};
  vrocm_wiring_t wl [5] = '{VROCM_WIRE_3LL_U4, VROCM_WIRE_3LL_U4, VROCM_WIRE_2LL_U3_U4,
    VROCM_WIRE_3LN, VROCM_WIRE_3LN};
  logic [1:0] rv [5] = '{2'b01, 2'b11, 2'b01, 2'b01, 2'b00};
  vrocm_vstat_t vs [5] = '{VROCM_VSTAT_POSSEQ_NA, VROCM_VSTAT_OK, VROCM_VSTAT_POSSEQ_NA,
    VROCM_VSTAT_OK, VROCM_VSTAT_INVALID};

  vrocm_stage #(.STEP_CYC(10)) uut (.ref_clk, .reset_n, .cycle_strobe, .time_ms, .meas,
    .block_in, .setting, .mode, .wiring, .residual_voltage_channel, .event_enable,
    .counter_clear, .record_index, .start_out, .trip_out, .blocked_out, .mode_status,
    .condition, .voltage_status, .pickup_now, .voltage_now, .ratio_now, .expected_time,
    .remaining_time, .faulted_phases, .start_count, .trip_count, .block_count,
    .event_out_valid, .event_out, .record_out, .record_count);
  vrocm_partner #(.PERIOD(8)) u_front (.ref_clk, .reset_n, .set_meas, .set_block,
    .cycle_strobe, .meas, .block_in);

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk)
    if (event_out_valid === 1'b1)
      last_ev <= event_out;

  task automatic strobes(input int n);
    repeat (n) @(negedge ref_clk iff cycle_strobe === 1'b1);
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic fault(input logic [15:0] amps, input logic blk);
    set_meas.il2 <= amps;
    set_block <= blk;
    strobes(3);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    time_ms = 48'h0000_0000_ABCD;
    set_block = 1'b0;
    set_meas = '{16'h0000, 16'h0000, 16'h0000, 16'h1770, 1'b1};
    setting = '{KNEE_LO_I_RST, KNEE_HI_I_RST, KNEE_LO_U_RST, KNEE_HI_U_RST, 1'b0, 19'h00010,
      16'h0064, 19'h00000, 3'h5};
    mode = VROCM_MODE_ON;
    wiring = VROCM_WIRE_3LN;
    residual_voltage_channel = 1'b0;
    event_enable = 6'h3F;
    counter_clear = 3'h0;
    record_index = 4'h0;
    repeat (8) @(negedge ref_clk);
    `CHK(condition, VROCM_COND_NORMAL);
    `CHK(voltage_status, VROCM_VSTAT_INVALID);
    `CHK(mode_status, VROCM_MODE_ON);
    reset_n = 1'b1;
    foreach (cv[k])
    begin
      setting.lower_voltage_knee = cv[k][0];
      setting.upper_voltage_knee = cv[k][1];
      set_meas.positive_sequence_voltage <= cv[k][2];
      strobes(2);
      `CHK(pickup_now, cv[k][3]);
      `CHK(voltage_now, cv[k][2]);
    end
    foreach (wl[k])
    begin
      wiring = wl[k];
      residual_voltage_channel = rv[k][1];
      set_meas.voltage_valid <= rv[k][0];
      strobes(2);
      `CHK(voltage_status, vs[k]);
    end
    wiring = VROCM_WIRE_3LN;
    setting.lower_voltage_knee = KNEE_LO_U_RST;
    setting.upper_voltage_knee = KNEE_HI_U_RST;
    set_meas <= '{16'h0000, 16'h0000, 16'h0000, 16'h1770, 1'b1};
    strobes(2);
    fault(16'h008C, 1'b0);
    `CHK(start_out, 1'b1);
    `CHK(condition, VROCM_COND_START);
    `CHK(ratio_now, 16'h00C8);
    `CHK(faulted_phases, 3'b010);
    `CHK(expected_time, 19'h00010);
    `CHK(remaining_time != 20'h00000, 1'b1);
    `CHK(last_ev, {48'h0000_0000_ABCD, VROCM_EV_START_ON});
    `CHK(start_count, 16'h0001);
    `CHK(record_count, 4'h1);
    `CHK(record_out.fault_current, 16'h008C);
    `CHK(record_out.faulted_phases, 3'b010);
    `CHK(record_out.pickup_level, 16'h0046);
    `CHK(record_out.setting_group, 3'h5);
    fault(16'h0045, 1'b0);
    `CHK(start_out, 1'b1);
    fault(16'h008C, 1'b0);
    setting.inverse_sel = 1'b1;
    strobes(2);
    `CHK(expected_time, 19'h00064);
    setting.inverse_sel = 1'b0;
    for (int i = 0; i < 400 && trip_out !== 1'b1; i++)
      @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    `CHK(trip_out, 1'b1);
    `CHK(condition, VROCM_COND_TRIP);
    `CHK(last_ev.event_code, VROCM_EV_TRIP_ON);
    `CHK(trip_count, 16'h0001);
    fault(16'h0000, 1'b0);
    strobes(2);
    `CHK({start_out, trip_out}, 2'b00);
    `CHK(remaining_time, 20'h00000);
    fault(16'h008C, 1'b1);
    `CHK({start_out, blocked_out}, 2'b01);
    `CHK(condition, VROCM_COND_BLOCKED);
    `CHK(block_count, 16'h0001);
    fault(16'h0000, 1'b0);
    fault(16'h008C, 1'b0);
    fault(16'h008C, 1'b1);
    `CHK({start_out, blocked_out}, 2'b01);
    fault(16'h0000, 1'b0);
    strobes(2);
    counter_clear = 3'h7;
    repeat (2) @(negedge ref_clk);
    counter_clear = 3'h0;
    `CHK({start_count, trip_count, block_count}, 48'h0);
    mode = VROCM_MODE_OFF;
    fault(16'h008C, 1'b0);
    `CHK({start_out, trip_out, blocked_out}, 3'b000);
    `CHK(mode_status, VROCM_MODE_OFF);
    mode = VROCM_MODE_TEST;
    event_enable = 6'h3E;
    repeat (11)
    begin
      fault(16'h0000, 1'b0);
      strobes(2);
      fault(16'h008C, 1'b0);
    end
    `CHK(record_count, 4'hC);
    `CHK(last_ev.event_code, VROCM_EV_START_OFF);
    results();
  end
endmodule
